// ===== lix_exec.sv
module lix_exec #(
    parameter int XLEN = lix_pkg::XLEN
) (
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    // Dispatch side
    input  wire logic               issue_valid,
    output logic                    issue_ready,
    input  wire logic [31:0]        issue_instr,
    input  wire logic [31:0]        base_val,
    input  wire logic [31:0]        index_val,
    output logic                    decode_invalid,
    output logic                    unknown_op,
    // Pipeline state and synchronizing events
    input  wire logic               older_done,
    input  wire logic               ctx_event,
    output logic                    fetch_hold,
    output logic                    flush_prefetch,
    output logic                    sync_done,
    // Memory path
    output logic                    mem_req,
    output lix_pkg::lix_mreq_t      mem_info,
    input  wire logic               mem_ack,
    input  wire logic [63:0]        mem_rdata,
    // Register writeback
    output logic                    gpr_we,
    output lix_pkg::lix_gwr_t       gpr_wr,
    output logic                    base_we,
    output lix_pkg::lix_gwr_t       base_wr,
    output logic                    fpr_we,
    output logic [4:0]              fpr_addr,
    output logic [63:0]             fpr_data
);
    // Register width is fixed by the field layout; refuse anything else at elaboration
    if (XLEN != 32) begin
        $error("lix_exec serves only 32-bit registers");
    end

    lix_pkg::lix_dec_t   dec;
    lix_pkg::lix_dec_t   held;
    lix_pkg::lix_state_t state;
    lix_pkg::lix_state_t next_state;
    logic [31:0]         ea;
    logic                ctx_pend;
    logic [63:0]         dbl;

    lix_decode u_dec (
        .instr (issue_instr),
        .dec   (dec)
    );

    lix_s2d u_s2d (
        .single_in  (mem_rdata[31:0]),
        .double_out (dbl)
    );

    // Effective address: base replaced by zero only on non-update forms
    wire logic [31:0] base_eff = (dec.base == 5'h00 && !dec.update) ? 32'h0 : base_val;
    wire logic [31:0] offset   = dec.indexed ? index_val : {{16{dec.disp[15]}}, dec.disp};
    wire logic [31:0] next_ea  = base_eff + offset;

    wire logic take     = issue_valid && issue_ready;
    wire logic is_load  = dec.kind inside {lix_pkg::LIX_K_BYTE, lix_pkg::LIX_K_SINGLE,
                                           lix_pkg::LIX_K_DOUBLE};
    wire logic go_mem   = take && is_load && !dec.invalid;
    wire logic go_sync  = take && dec.kind == lix_pkg::LIX_K_SYNC;
    wire logic done_mem = state == lix_pkg::LIX_MEM && mem_ack;
    wire logic drained  = state == lix_pkg::LIX_DRAIN && older_done;
    // A held event counts as a fresh one once the state is back in idle
    wire logic ctx_go   = ctx_event || ctx_pend;

    // Nothing new accepted while a load, drain or flush is pending
    assign issue_ready    = state == lix_pkg::LIX_IDLE && !ctx_pend;
    assign fetch_hold     = state != lix_pkg::LIX_IDLE || ctx_pend;
    assign flush_prefetch = state == lix_pkg::LIX_FLUSH;
    assign mem_req        = state == lix_pkg::LIX_MEM;

    // Next-state selection
    always_comb begin
        next_state = state;
        unique case (state)
            lix_pkg::LIX_IDLE: begin
                if (go_mem) next_state = lix_pkg::LIX_MEM;
                else if (go_sync || ctx_go) next_state = lix_pkg::LIX_DRAIN;
            end
            lix_pkg::LIX_MEM: begin
                if (mem_ack) next_state = lix_pkg::LIX_IDLE;
            end
            lix_pkg::LIX_DRAIN: begin
                if (older_done) next_state = lix_pkg::LIX_FLUSH;
            end
            lix_pkg::LIX_FLUSH: next_state = lix_pkg::LIX_IDLE;
            default: next_state = lix_pkg::LIX_IDLE;
        endcase
    end

    // State, held decode and pending synchronizing event
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state    <= lix_pkg::LIX_IDLE;
            held     <= '0;
            ea       <= 32'h0;
            ctx_pend <= 1'b0;
        end else begin
            state <= next_state;
            if (take) begin
                held <= dec;
                ea   <= next_ea;
            end
            // Event in any non-idle state (load, drain or flush), or beside a load just taken, waits; set wins
            if (ctx_event && (state != lix_pkg::LIX_IDLE || go_mem)) ctx_pend <= 1'b1;
            else if (state == lix_pkg::LIX_IDLE && !go_mem) ctx_pend <= 1'b0;
        end
    end

    // Memory request fields, registered on acceptance
    always_comb begin
        mem_info.ea   = ea;
        mem_info.fp   = held.kind != lix_pkg::LIX_K_BYTE;
        mem_info.tgt  = held.tgt;
        mem_info.size = held.kind == lix_pkg::LIX_K_BYTE ? lix_pkg::SIZE_BYTE
                      : held.kind == lix_pkg::LIX_K_SINGLE ? lix_pkg::SIZE_WORD
                      : lix_pkg::SIZE_DWORD;
    end

    // Writeback and status outputs come from flip-flops
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            gpr_we         <= 1'b0;
            gpr_wr         <= '0;
            base_we        <= 1'b0;
            base_wr        <= '0;
            fpr_we         <= 1'b0;
            fpr_addr       <= 5'h00;
            fpr_data       <= 64'h0;
            decode_invalid <= 1'b0;
            unknown_op     <= 1'b0;
            sync_done      <= 1'b0;
        end else begin
            decode_invalid <= take && dec.invalid;
            unknown_op     <= take && dec.kind == lix_pkg::LIX_K_NONE;
            sync_done      <= state == lix_pkg::LIX_FLUSH;
            gpr_we         <= done_mem && held.kind == lix_pkg::LIX_K_BYTE;
            gpr_wr.addr    <= held.tgt;
            gpr_wr.data    <= {24'h000000, mem_rdata[7:0]};
            base_we        <= done_mem && held.update;
            base_wr.addr   <= held.base;
            base_wr.data   <= ea;
            fpr_we         <= done_mem && held.kind != lix_pkg::LIX_K_BYTE;
            fpr_addr       <= held.tgt;
            fpr_data       <= held.kind == lix_pkg::LIX_K_SINGLE ? dbl : mem_rdata;
        end
    end

    // Sync drains then flushes before any new acceptance
    sync_block_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        go_sync |=> state == lix_pkg::LIX_DRAIN) else $error("sync not draining");
    drain_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state == lix_pkg::LIX_DRAIN && !older_done) |=> state == lix_pkg::LIX_DRAIN)
        else $error("drain left early");
    flush_once_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        drained |=> flush_prefetch ##1 (sync_done && !flush_prefetch))
        else $error("flush sequence wrong");
    sync_nomem_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        state inside {lix_pkg::LIX_DRAIN, lix_pkg::LIX_FLUSH} |-> !mem_req)
        else $error("sync touched memory");
    no_issue_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        fetch_hold |-> !issue_ready) else $error("issue during hold");
    ctx_event_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (ctx_event && state == lix_pkg::LIX_IDLE && !go_mem && !ctx_pend)
        |=> state == lix_pkg::LIX_DRAIN) else $error("event not synchronizing");
    byte_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        gpr_we |-> gpr_wr.data[31:8] == 24'h000000) else $error("byte not zeroed");
    bad_noupd_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (take && dec.invalid) |=> decode_invalid && state != lix_pkg::LIX_MEM)
        else $error("invalid form executed");
    upd_addr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        base_we |-> base_wr.addr != 5'h00 && base_wr.data == $past(ea))
        else $error("bad base update");
    ea_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        go_mem && !dec.update && dec.base == 5'h00 |=> ea == $past(offset))
        else $error("zero base not used");
    double_only_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        fpr_we && $past(held.kind) == lix_pkg::LIX_K_DOUBLE && !$past(held.update) |-> !gpr_we && !base_we)
        else $error("double altered gpr");
    pend_drain_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (ctx_pend && state == lix_pkg::LIX_IDLE) |=> state == lix_pkg::LIX_DRAIN)
        else $error("pending event lost");
endmodule

// ===== lix_pkg.sv
package lix_pkg;
    localparam int          XLEN        = 32;
    localparam logic [5:0]  OP_SYNC     = 6'h13;
    localparam logic [5:0]  OP_EXT      = 6'h1F;
    localparam logic [5:0]  OP_LBZ      = 6'h22;
    localparam logic [5:0]  OP_LBZU     = 6'h23;
    localparam logic [5:0]  OP_LFS      = 6'h30;
    localparam logic [5:0]  OP_LFSU     = 6'h31;
    localparam logic [5:0]  OP_LFD      = 6'h32;
    localparam logic [5:0]  OP_LFDU     = 6'h33;
    localparam logic [9:0]  XO_SYNC     = 10'h096;
    localparam logic [9:0]  XO_LBZX     = 10'h057;
    localparam logic [9:0]  XO_LBZUX    = 10'h077;
    localparam logic [9:0]  XO_LFDX     = 10'h257;
    localparam logic [9:0]  XO_LFDUX    = 10'h277;
    // Field positions, little-endian index of big-endian bit 0 = 31
    localparam int          POS_OPC     = 26;
    localparam int          POS_TGT     = 21;
    localparam int          POS_BASE    = 16;
    localparam int          POS_IDX     = 11;
    localparam int          POS_XO      = 1;
    localparam logic [3:0]  SIZE_BYTE   = 4'h1;
    localparam logic [3:0]  SIZE_WORD   = 4'h4;
    localparam logic [3:0]  SIZE_DWORD  = 4'h8;

    typedef enum logic [2:0] {
        LIX_K_NONE   = 3'h0,
        LIX_K_BYTE   = 3'h1,
        LIX_K_SINGLE = 3'h2,
        LIX_K_DOUBLE = 3'h3,
        LIX_K_SYNC   = 3'h4
    } lix_kind_t;

    typedef struct packed {
        lix_kind_t   kind;
        logic        indexed;
        logic        update;
        logic        invalid;
        logic [4:0]  tgt;
        logic [4:0]  base;
        logic [4:0]  idx;
        logic [15:0] disp;
    } lix_dec_t;

    typedef struct packed {
        logic [31:0] ea;
        logic [3:0]  size;
        logic        fp;
        logic [4:0]  tgt;
    } lix_mreq_t;

    typedef struct packed {
        logic [4:0]  addr;
        logic [31:0] data;
    } lix_gwr_t;

    typedef enum logic [3:0] {
        LIX_IDLE  = 4'b0001,
        LIX_MEM   = 4'b0010,
        LIX_DRAIN = 4'b0100,
        LIX_FLUSH = 4'b1000
    } lix_state_t;
endpackage

// ===== lix_decode.sv
module lix_decode (
    input  wire logic [31:0]      instr,
    output lix_pkg::lix_dec_t     dec
);
    wire logic [5:0] opc  = instr[lix_pkg::POS_OPC +: 6];
    wire logic [9:0] xo   = instr[lix_pkg::POS_XO +: 10];
    wire logic [4:0] tgt  = instr[lix_pkg::POS_TGT +: 5];
    wire logic [4:0] base = instr[lix_pkg::POS_BASE +: 5];
    wire logic [4:0] idx  = instr[lix_pkg::POS_IDX +: 5];
    wire logic is_sync  = opc == lix_pkg::OP_SYNC && xo == lix_pkg::XO_SYNC
                          && instr[25:11] == 15'h0000 && !instr[0];
    wire logic is_x     = opc == lix_pkg::OP_EXT && !instr[0];
    wire logic lbz      = opc == lix_pkg::OP_LBZ;
    wire logic lbzu     = opc == lix_pkg::OP_LBZU;
    wire logic lbzx     = is_x && xo == lix_pkg::XO_LBZX;
    wire logic lbzux    = is_x && xo == lix_pkg::XO_LBZUX;
    wire logic lfd      = opc == lix_pkg::OP_LFD;
    wire logic lfdu     = opc == lix_pkg::OP_LFDU;
    wire logic lfdx     = is_x && xo == lix_pkg::XO_LFDX;
    wire logic lfdux    = is_x && xo == lix_pkg::XO_LFDUX;
    wire logic lfs      = opc == lix_pkg::OP_LFS;
    wire logic lfsu     = opc == lix_pkg::OP_LFSU;
    wire logic byte_op  = lbz | lbzu | lbzx | lbzux;
    wire logic upd      = lbzu | lbzux | lfdu | lfdux | lfsu;
    // Byte updates also clash when target equals base; fp targets differ
    wire logic bad      = upd && (base == 5'h00 || (byte_op && base == tgt));

    // Decoded fields travel together
    always_comb begin
        dec.kind    = is_sync ? lix_pkg::LIX_K_SYNC
                    : byte_op ? lix_pkg::LIX_K_BYTE
                    : (lfd | lfdu | lfdx | lfdux) ? lix_pkg::LIX_K_DOUBLE
                    : (lfs | lfsu) ? lix_pkg::LIX_K_SINGLE
                    : lix_pkg::LIX_K_NONE;
        dec.indexed = lbzx | lbzux | lfdx | lfdux;
        dec.update  = upd;
        dec.invalid = bad;
        dec.tgt     = tgt;
        dec.base    = base;
        dec.idx     = idx;
        dec.disp    = instr[15:0];
    end
endmodule

// ===== lix_s2d.sv
module lix_s2d (
    input  wire logic [31:0] single_in,
    output logic      [63:0] double_out
);
    wire logic       sgn  = single_in[31];
    wire logic [7:0] expo = single_in[30:23];
    wire logic [22:0] man = single_in[22:0];
    logic [4:0]  lz;
    logic [22:0] nman;

    // Widen single to double; denormals renormalised
    always_comb begin
        lz   = 5'h00;
        nman = 23'h000000;
        for (int i = 22; i >= 0; i--) begin
            if (man[i] && nman == 23'h000000) begin
                lz   = 5'(22 - i);
                nman = 23'(man << (23 - i));
            end
        end
        if (expo == 8'hFF) begin
            double_out = {sgn, 11'h7FF, man, 29'h00000000};
        end else if (expo != 8'h00) begin
            double_out = {sgn, 11'(expo) + 11'h380, man, 29'h00000000};
        end else if (man == 23'h000000) begin
            double_out = {sgn, 63'h0};
        end else begin
            double_out = {sgn, 11'h381 - 11'(lz) - 11'h001, nman, 29'h00000000};
        end
    end
endmodule

// ===== lix_mem_model.sv
module lix_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        mem_req,
    input  wire logic [3:0]  delay,
    input  wire logic [63:0] rd_val,
    output logic             mem_ack,
    output logic [63:0]      mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt;

    // Ack after the set delay; data toggles outside the ack so stale values never pass
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mem_ack   <= 1'b0;
            wait_cnt  <= 4'h0;
            mem_rdata <= 64'h0;
        end else if (mem_ack) begin
            mem_ack   <= 1'b0;
            wait_cnt  <= 4'h0;
            mem_rdata <= ~mem_rdata;
        end else if (mem_req && wait_cnt == delay) begin
            mem_ack   <= 1'b1;
            mem_rdata <= rd_val;
        end else begin
            mem_rdata <= ~mem_rdata;
            wait_cnt  <= mem_req ? wait_cnt + 4'h1 : wait_cnt;
        end
    end
endmodule

// ===== tb.sv
`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp); \
        end \
    end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REQ = 0, GPR = 1, BAS = 2, FPR = 3, INV = 4;
    localparam int UNK = 5, FLS = 6, DON = 7, RDY = 8, HLD = 9;
    // Low byte E9 and low word a normal single; widened value worked out by hand
    localparam logic [63:0] MEM = 64'h89AB_CDEF_C120_00E9;
    localparam logic [63:0] SGL = 64'hC024_001D_2000_0000;
    logic               ref_clk, resetn, issue_valid, issue_ready, older_done, ctx_event;
    logic [31:0]        issue_instr, base_val, index_val;
    logic               decode_invalid, unknown_op, fetch_hold, flush_prefetch, sync_done;
    logic               mem_req, mem_ack, gpr_we, base_we, fpr_we;
    logic [3:0]         delay;
    logic [4:0]         fpr_addr, seen_fa;
    logic [63:0]        mem_rdata, fpr_data, seen_fpr;
    lix_pkg::lix_mreq_t mem_info, seen_info;
    lix_pkg::lix_gwr_t  gpr_wr, base_wr, seen_gpr, seen_base;
    int                 miscompares, n_tests, at_flush, at_done, at_gpr;
    int                 cnt[10];

    lix_exec u_dut (.ref_clk(ref_clk), .resetn(resetn), .issue_valid(issue_valid),
        .issue_ready(issue_ready), .issue_instr(issue_instr), .base_val(base_val),
        .index_val(index_val), .decode_invalid(decode_invalid), .unknown_op(unknown_op),
        .older_done(older_done), .ctx_event(ctx_event), .fetch_hold(fetch_hold),
        .flush_prefetch(flush_prefetch), .sync_done(sync_done), .mem_req(mem_req),
        .mem_info(mem_info), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .gpr_we(gpr_we),
        .gpr_wr(gpr_wr), .base_we(base_we), .base_wr(base_wr), .fpr_we(fpr_we),
        .fpr_addr(fpr_addr), .fpr_data(fpr_data));
    lix_mem_model u_mem (.ref_clk(ref_clk), .resetn(resetn), .mem_req(mem_req),
        .delay(delay), .rd_val(MEM), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    always #2 ref_clk = ~ref_clk;

    function automatic logic [31:0] d_i(input logic [5:0] op, input logic [4:0] t, b,
                                        input logic [15:0] d);
        return {op, t, b, d};
    endfunction
    function automatic logic [31:0] x_i(input logic [4:0] t, b, x, input logic [9:0] xo);
        return {6'h1F, t, b, x, xo, 1'b0};
    endfunction

    // Hold the offer until taken, then scramble operands so late sampling shows
    task automatic issue(input logic [31:0] ins, bv, iv);
        int n;
        n = 0;
        @(posedge ref_clk);
        issue_valid <= 1'b1;
        issue_instr <= ins;
        base_val    <= bv;
        index_val   <= iv;
        do begin
            @(negedge ref_clk);
            n++;
        end while (!issue_ready && n < 50);
        @(posedge ref_clk);
        issue_valid <= 1'b0;
        base_val    <= ~bv;
        index_val   <= ~iv;
        issue_instr <= ~ins;
    endtask

    // Count output activity over a window, sampled mid-cycle
    task automatic watch(input int cycles);
        cnt = '{default: 0};
        at_flush = 0;
        at_done = 0;
        at_gpr = 0;
        for (int i = 1; i <= cycles; i++) begin
            @(negedge ref_clk);
            if (mem_req && cnt[REQ] == 0) seen_info = mem_info;
            if (gpr_we) seen_gpr = gpr_wr;
            if (gpr_we) at_gpr = i;
            if (base_we) seen_base = base_wr;
            if (fpr_we) seen_fa = fpr_addr;
            if (fpr_we) seen_fpr = fpr_data;
            if (flush_prefetch) at_flush = i;
            if (sync_done) at_done = i;
            cnt[REQ] += mem_req;
            cnt[GPR] += gpr_we;
            cnt[BAS] += base_we;
            cnt[FPR] += fpr_we;
            cnt[INV] += decode_invalid;
            cnt[UNK] += unknown_op;
            cnt[FLS] += flush_prefetch;
            cnt[DON] += sync_done;
            cnt[RDY] += issue_ready;
            cnt[HLD] += fetch_hold;
        end
    endtask

    task automatic run_load(input logic [31:0] ins, bv, iv, ea, input int size, upd, dly);
        logic [63:0] want;
        want = (size == 8) ? MEM : (size == 4) ? SGL : {56'h0, MEM[7:0]};
        @(posedge ref_clk);
        delay <= 4'(dly);
        issue(ins, bv, iv);
        watch(16);
        `CHK(seen_info.ea, ea)
        `CHK(seen_info.size, 4'(size))
        `CHK(seen_info.fp, size != 1)
        `CHK(seen_info.tgt, ins[25:21])
        `CHK(cnt[GPR] + cnt[FPR], 1)
        `CHK(cnt[BAS], upd)
        if (upd) `CHK(seen_base, {ins[20:16], ea})
        if (size == 1) `CHK(seen_gpr, {ins[25:21], want[31:0]})
        else `CHK({seen_fa, seen_fpr}, {ins[25:21], want})
        $display("test %h finished", ins);
    endtask

    // Bad update forms: flagged, nothing loaded or written
    task automatic run_bad(input logic [31:0] ins);
        issue(ins, 32'h0000_1000, 32'h0000_0020);
        watch(6);
        `CHK(cnt[INV], 1)
        `CHK(cnt[REQ] + cnt[GPR] + cnt[BAS] + cnt[FPR], 0)
        $display("test %h finished", ins);
    endtask

    // Malformed synchronize words must not drain the pipeline
    task automatic run_odd(input logic [31:0] ins);
        issue(ins, 32'h0, 32'h0);
        watch(6);
        `CHK(cnt[UNK], 1)
        `CHK(cnt[HLD] + cnt[REQ] + cnt[FLS], 0)
        $display("test %h finished", ins);
    endtask

    task automatic run_sync;
        @(posedge ref_clk);
        older_done <= 1'b0;
        issue(32'h4C00_012C, 32'h0, 32'h0);
        watch(6);
        `CHK(cnt[FLS] + cnt[DON], 0)
        `CHK({cnt[RDY], cnt[HLD]}, {32'd0, 32'd6})
        @(posedge ref_clk);
        older_done <= 1'b1;
        watch(8);
        `CHK(cnt[FLS], 1)
        `CHK(at_done, at_flush + 1)
        `CHK(cnt[REQ], 0)
        $display("test sync finished");
    endtask

    // Event while idle, then one arriving in the first cycle of a slow load
    task automatic run_event;
        @(posedge ref_clk);
        ctx_event <= 1'b1;
        @(posedge ref_clk);
        ctx_event <= 1'b0;
        watch(8);
        `CHK({cnt[FLS], at_done}, {32'd1, at_flush + 1})
        delay <= 4'h6;
        issue(d_i(6'h22, 5'h02, 5'h00, 16'h0001), 32'h0, 32'h0);
        ctx_event <= 1'b1;
        fork
            watch(20);
            @(posedge ref_clk) ctx_event <= 1'b0;
        join
        `CHK({cnt[FLS], cnt[GPR], 32'(at_flush > at_gpr)}, {32'd1, 32'd1, 32'd1})
        $display("test event finished");
    endtask

    task automatic close_out;
        $display("comparisons %0d, wrong %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; this is ample margin
    initial begin
        #20000;
        miscompares++;
        close_out();
    end

    initial begin
        ref_clk = 1'b0;
        resetn = 1'b0;
        issue_valid = 1'b0;
        issue_instr = 32'h0;
        base_val = 32'h0;
        index_val = 32'h0;
        older_done = 1'b1;
        ctx_event = 1'b0;
        delay = 4'h0;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        run_load(d_i(6'h22, 5'h04, 5'h00, 16'hFFF0), 32'h1234_0000, 0, 32'hFFFF_FFF0, 1, 0, 0);
        run_load(d_i(6'h22, 5'h07, 5'h09, 16'h0010), 32'h2000, 0, 32'h2010, 1, 0, 3);
        run_load(d_i(6'h23, 5'h04, 5'h03, 16'h8000), 32'h1_0000, 0, 32'h8000, 1, 1, 0);
        run_load(x_i(5'h05, 5'h06, 5'h07, 10'h077), 32'h1000_0000, 32'h123, 32'h1000_0123, 1, 1, 5);
        run_load(x_i(5'h05, 5'h00, 5'h07, 10'h057), 32'hDEAD_0000, 32'h400, 32'h400, 1, 0, 0);
        run_load(d_i(6'h32, 5'h11, 5'h00, 16'h0008), 32'h7777, 0, 32'h8, 8, 0, 2);
        run_load(d_i(6'h33, 5'h1F, 5'h02, 16'hFFF8), 32'h100, 0, 32'hF8, 8, 1, 0);
        run_load(x_i(5'h01, 5'h02, 5'h03, 10'h277), 32'h8000_0000, 32'h10, 32'h8000_0010, 8, 1, 0);
        run_load(x_i(5'h02, 5'h00, 5'h03, 10'h257), 32'h5555, 32'h40, 32'h40, 8, 0, 4);
        run_load(d_i(6'h30, 5'h0A, 5'h00, 16'h0004), 32'h9999, 0, 32'h4, 4, 0, 0);
        run_load(d_i(6'h31, 5'h0B, 5'h0C, 16'h0020), 32'h100, 0, 32'h120, 4, 1, 1);
        run_bad(d_i(6'h23, 5'h01, 5'h00, 16'h0004));
        run_bad(d_i(6'h23, 5'h04, 5'h04, 16'h0004));
        run_bad(x_i(5'h06, 5'h06, 5'h01, 10'h077));
        run_bad(d_i(6'h33, 5'h01, 5'h00, 16'h0008));
        run_bad(x_i(5'h01, 5'h00, 5'h02, 10'h277));
        run_bad(d_i(6'h31, 5'h01, 5'h00, 16'h0004));
        run_odd(32'h4C00_012D);
        run_odd(32'h4C20_012C);
        run_sync();
        run_event();
        close_out();
    end
endmodule
